// [rtl/svr_pkg.sv]
// Package: types and constants of the vector register file and accumulator
package svr_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned GPR_COUNT = 32;
  localparam int unsigned GPR_WIDTH = 64;
  localparam int unsigned WORD_WIDTH = 32;
  localparam int unsigned HALF_WIDTH = 16;
  localparam int unsigned BYTE_WIDTH = 8;
  localparam int unsigned BYTE_LANES = 8;
  localparam int unsigned WORD_LANES = 2;
  localparam int unsigned SCR_WIDTH = 32;
  localparam logic [9:0] SCR_SPR_NUMBER = 10'h200;

  // ---------------------------------------------------------------
  // Status/control layout (vector bit positions, MSB-first index 0 = bit 31)
  // ---------------------------------------------------------------
  localparam int unsigned SCR_SUMMARY_OVERFLOW_HIGH = 31;
  localparam int unsigned SCR_OVH = 30;
  localparam int unsigned SCR_FPH_LSB = 24;
  localparam int unsigned SCR_SOVL = 15;
  localparam int unsigned SCR_OVL = 14;
  localparam int unsigned SCR_FPL_LSB = 8;
  localparam int unsigned FP_FLAGS = 6;
  localparam logic [31:0] SCR_WRITE_MASK = 32'hff7fff7f;
  localparam logic [31:0] SCR_RESET = 32'h00000000;
  localparam logic [63:0] GPR_RESET = 64'h0000000000000000;
  localparam logic [63:0] ACC_RESET = 64'h0000000000000000;
  localparam logic [31:0] SAT_POS = 32'h7fffffff;
  localparam logic [31:0] SAT_NEG = 32'h80000000;

  // ---------------------------------------------------------------
  // Operations and element sizes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SCALAR_WR = 4'h1,
    OP_BRINC_WR = 4'h2,
    OP_VEC_WR = 4'h3,
    OP_VEC_ACC_WR = 4'h4,
    OP_MOVE_TO_ACC = 4'h5,
    OP_MOVE_FROM_ACC = 4'h6,
    OP_MAC_HFRAC = 4'h7,
    OP_VEC_CMP = 4'h8,
    OP_VEC_SETCMP = 4'h9,
    OP_MOVE_TO_SCR = 4'ha
  } svr_op_type;

  typedef enum logic [1:0] {
    EL_WORD = 2'h0,
    EL_HALF = 2'h1,
    EL_BYTE = 2'h2
  } svr_elem_type;

  typedef struct packed {
    logic valid;
    svr_op_type op;
    logic [4:0] dest;
    logic [4:0] src_a;
    logic [2:0] crf;
    svr_elem_type elem;
    logic saturate;
    logic [7:0] cmp_mask;
    logic flag_upd;
    logic ovf_high;
    logic ovf_low;
    logic [5:0] fp_high;
    logic [5:0] fp_low;
    logic [63:0] wdata;
    logic [63:0] bdata;
  } svr_req_type;

  typedef struct packed {
    logic valid;
    logic [2:0] field;
    logic [3:0] bits;
  } svr_cond_type;

  // Signed fractional product: low x+y-1 bits with a zero appended
  function automatic logic [31:0] svr_sf_mul16(input logic [15:0] x, input logic [15:0] y);
    logic signed [31:0] p;
    p = $signed(x) * $signed(y);
    return {p[30:0], 1'b0};
  endfunction

endpackage

// [rtl/svr_regfile.sv]
// Vector register file, accumulator and shared status/control register
`timescale 1ns/1ns

// Summary of operation
// - Each register is a vector of two, four or eight equal elements.
// - Bit index 0 is the MSB, 63 the LSB; 32-bit registers run 32..63.
// - Word element 0 is bits 0-31, word element 1 is bits 32-63.
// - Halfwords 0..3 are 16-bit slices from the MSB end.
// - Bytes 0..7 are 8-bit slices from the MSB end.
// - Thirty-two 64-bit registers shared by scalar and vector instructions.
// - Scalar instructions change only the low 32 bits, upper half kept.
// - Vector instructions write all 64 destination bits by default.
// - Each element result is computed independently of the others.
// - Compare writes a 4-bit field: high, low, OR and AND results.
// - Set-compare writes per-element booleans into a destination register.
// - Accumulator is 64 bits, viewed as one, two, four or eight elements.
// - Accumulating instructions also write their result to the destination.
// - Move-from-accumulator copies the whole accumulator into a register.
// - Halfword fractional MAC: multiply low halves, add, saturate, write both.
// - Fractional product keeps low x+y-1 bits and appends a zero.
// - Status/control is special register 512, writable in any privilege.
// - Vector instructions update high flags (0-1) and low flags (16-17).
// - Summary overflow high sets with overflow high, cleared only by a move.
// - Overflow high sets when the upper half of a result overflows.
// - High floating-point flags occupy bits 2 through 7.
// - Summary overflow low sets with overflow low, cleared only by a move.
// - Vector instructions raise unavailable when the extension is disabled.
module svr_regfile
  import svr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire svr_req_type req,
  input wire logic simd_extension,
  input wire logic [4:0] rd_a_addr,
  input wire logic [4:0] rd_b_addr,
  output logic [63:0] rd_a_data,
  output logic [63:0] rd_b_data,
  output logic [63:0] acc_data,
  output logic [31:0] simd_status_control,
  output svr_cond_type cond_out,
  output logic unavail_exc
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [GPR_COUNT-1:0][GPR_WIDTH-1:0] gpr;
    logic [63:0] acc;
    logic [31:0] scr;
    logic [63:0] rd_a;
    logic [63:0] rd_b;
    svr_cond_type cond;
    logic unavail;
  } svr_state_type;

  svr_state_type st_reg;
  svr_state_type st_next;

  logic is_vector;
  logic blocked;
  logic [63:0] src_a_val;
  logic [63:0] src_b_val;
  logic [63:0] mac_result;
  logic [WORD_LANES-1:0] mac_ovf;
  logic [63:0] set_mask;
  logic [3:0] cmp_bits;

  // ---------------------------------------------------------------
  // Instruction class
  // ---------------------------------------------------------------
  always_comb begin
    unique case (req.op)
      OP_NONE, OP_SCALAR_WR, OP_BRINC_WR, OP_MOVE_TO_SCR: is_vector = 1'b0;
      default: is_vector = 1'b1;
    endcase
  end

  assign blocked = req.valid && is_vector && !simd_extension;
  assign src_a_val = st_reg.gpr[req.src_a];
  assign src_b_val = req.bdata;
  assign cmp_bits = {req.cmp_mask[0], req.cmp_mask[1],
                     req.cmp_mask[0] | req.cmp_mask[1],
                     req.cmp_mask[0] & req.cmp_mask[1]};

  // ---------------------------------------------------------------
  // Word lanes of the fractional MAC
  // ---------------------------------------------------------------
  // Lane 0 is the high word (MSB-first bits 0-31), lane 1 the low word.
  for (genvar w = 0; w < WORD_LANES; w++) begin : g_mac
    localparam int unsigned TOP = GPR_WIDTH - 1 - w * WORD_WIDTH;
    logic [15:0] half_a;
    logic [15:0] half_b;
    logic [31:0] prod;
    logic [31:0] acc_w;
    logic [32:0] sum;
    logic ovf;
    assign half_a = src_a_val[TOP-HALF_WIDTH:TOP-WORD_WIDTH+1];
    assign half_b = src_b_val[TOP-HALF_WIDTH:TOP-WORD_WIDTH+1];
    assign prod = svr_sf_mul16(half_a, half_b);
    assign acc_w = st_reg.acc[TOP:TOP-WORD_WIDTH+1];
    assign sum = {acc_w[31], acc_w} + {prod[31], prod};
    assign ovf = sum[32] ^ sum[31];
    assign mac_ovf[w] = ovf;
    always_comb begin
      if (ovf && req.saturate) begin
        mac_result[TOP:TOP-WORD_WIDTH+1] = sum[32] ? SAT_NEG : SAT_POS;
      end else begin
        mac_result[TOP:TOP-WORD_WIDTH+1] = sum[31:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Byte lanes of the set-compare result
  // ---------------------------------------------------------------
  // Byte j is MSB-first bits 8j..8j+7, so element 0 sits at the top.
  for (genvar j = 0; j < BYTE_LANES; j++) begin : g_set
    localparam int unsigned TOP = GPR_WIDTH - 1 - j * BYTE_WIDTH;
    logic pick;
    always_comb begin
      unique case (req.elem)
        EL_BYTE: pick = req.cmp_mask[j];
        EL_HALF: pick = req.cmp_mask[j/2];
        EL_WORD: pick = req.cmp_mask[j/4];
        default: pick = 1'b0;
      endcase
    end
    assign set_mask[TOP:TOP-BYTE_WIDTH+1] = {BYTE_WIDTH{pick}};
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Reads see the state before a same-edge write
    st_next.rd_a = st_reg.gpr[rd_a_addr];
    st_next.rd_b = st_reg.gpr[rd_b_addr];
    st_next.cond.valid = 1'b0;
    st_next.unavail = blocked;
    if (req.valid && !blocked) begin
      unique case (req.op)
        OP_SCALAR_WR, OP_BRINC_WR: begin
          st_next.gpr[req.dest][31:0] = req.wdata[31:0];
        end
        OP_VEC_WR: begin
          st_next.gpr[req.dest] = req.wdata;
        end
        OP_VEC_ACC_WR: begin
          st_next.gpr[req.dest] = req.wdata;
          st_next.acc = req.wdata;
        end
        OP_MOVE_TO_ACC: begin
          st_next.acc = src_a_val;
        end
        OP_MOVE_FROM_ACC: begin
          st_next.gpr[req.dest] = st_reg.acc;
        end
        OP_MAC_HFRAC: begin
          st_next.gpr[req.dest] = mac_result;
          st_next.acc = mac_result;
        end
        OP_VEC_CMP: begin
          st_next.cond.valid = 1'b1;
          st_next.cond.field = req.crf;
          st_next.cond.bits = cmp_bits;
        end
        OP_VEC_SETCMP: begin
          st_next.gpr[req.dest] = set_mask;
        end
        OP_MOVE_TO_SCR: begin
          st_next.scr = req.wdata[31:0] & SCR_WRITE_MASK;
        end
        default: begin
        end
      endcase
      // Flag updates follow the load so a set wins over a same-cycle clear
      if (is_vector && req.op == OP_MAC_HFRAC) begin
        st_next.scr[SCR_OVH] = mac_ovf[0];
        st_next.scr[SCR_OVL] = mac_ovf[1];
      end else if (is_vector && req.flag_upd) begin
        st_next.scr[SCR_OVH] = req.ovf_high;
        st_next.scr[SCR_OVL] = req.ovf_low;
        st_next.scr[SCR_FPH_LSB +: FP_FLAGS] = req.fp_high;
        st_next.scr[SCR_FPL_LSB +: FP_FLAGS] = req.fp_low;
      end
      if (st_next.scr[SCR_OVH] && is_vector) begin
        st_next.scr[SCR_SUMMARY_OVERFLOW_HIGH] = 1'b1;
      end
      if (st_next.scr[SCR_OVL] && is_vector) begin
        st_next.scr[SCR_SOVL] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < GPR_COUNT; i++) begin
        st_reg.gpr[i] <= GPR_RESET;
      end
      st_reg.acc <= ACC_RESET;
      st_reg.scr <= SCR_RESET;
      st_reg.rd_a <= GPR_RESET;
      st_reg.rd_b <= GPR_RESET;
      st_reg.cond <= '0;
      st_reg.unavail <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_a_data = st_reg.rd_a;
  assign rd_b_data = st_reg.rd_b;
  assign acc_data = st_reg.acc;
  assign simd_status_control = st_reg.scr;
  assign cond_out = st_reg.cond;
  assign unavail_exc = st_reg.unavail;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Every check is on clk; all but reset_clear_a idle while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence issue_s(svr_op_type o);
    req.valid && req.op == o && (simd_extension || !is_vector);
  endsequence

  sequence mac_issue_s;
    req.valid && req.op == OP_MAC_HFRAC && simd_extension;
  endsequence

  scalar_upper_keep_a: assert property (issue_s(OP_SCALAR_WR) |=>
    st_reg.gpr[$past(req.dest)][63:32] == $past(st_reg.gpr[req.dest][63:32])
    && st_reg.gpr[$past(req.dest)][31:0] == $past(req.wdata[31:0]))
    else $error("scalar write disturbed the upper word");

  vector_full_write_a: assert property (issue_s(OP_VEC_WR) |=>
    st_reg.gpr[$past(req.dest)] == $past(req.wdata))
    else $error("vector write did not load all 64 bits");

  move_from_acc_a: assert property (issue_s(OP_MOVE_FROM_ACC) |=>
    st_reg.gpr[$past(req.dest)] == $past(st_reg.acc))
    else $error("accumulator not copied to register");

  mac_dual_write_a: assert property (mac_issue_s |=>
    st_reg.gpr[$past(req.dest)] == acc_data && acc_data == $past(mac_result))
    else $error("accumulate result differs between accumulator and register");

  mac_overflow_flag_a: assert property (mac_issue_s ##0 mac_ovf[0] |=>
    simd_status_control[SCR_OVH] && simd_status_control[SCR_SUMMARY_OVERFLOW_HIGH])
    else $error("high overflow not flagged after accumulate");

  sticky_high_a: assert property (simd_status_control[SCR_SUMMARY_OVERFLOW_HIGH]
    && !(req.valid && req.op == OP_MOVE_TO_SCR) |=> simd_status_control[SCR_SUMMARY_OVERFLOW_HIGH])
    else $error("summary overflow high dropped without a move");

  sticky_low_a: assert property (simd_status_control[SCR_SOVL]
    && !(req.valid && req.op == OP_MOVE_TO_SCR) |=> simd_status_control[SCR_SOVL])
    else $error("summary overflow low dropped without a move");

  scr_load_a: assert property (issue_s(OP_MOVE_TO_SCR) |=>
    simd_status_control == ($past(req.wdata[31:0]) & SCR_WRITE_MASK))
    else $error("status/control move did not load the written value");

  unavail_a: assert property (blocked |=> unavail_exc
    && st_reg.gpr == $past(st_reg.gpr) && acc_data == $past(acc_data))
    else $error("vector op executed while the extension was disabled");

  cond_field_a: assert property (issue_s(OP_VEC_CMP) |=> cond_out.valid
    && cond_out.field == $past(req.crf)
    && cond_out.bits[3] == $past(req.cmp_mask[0])
    && cond_out.bits[2] == $past(req.cmp_mask[1])
    && cond_out.bits[1] == (cond_out.bits[3] | cond_out.bits[2])
    && cond_out.bits[0] == (cond_out.bits[3] & cond_out.bits[2])
    ##1 (!cond_out.valid || $past(req.valid && req.op == OP_VEC_CMP)))
    else $error("compare condition field malformed");

  // Reset check overrides the default disable
  reset_clear_a: assert property (disable iff (1'b0) !rst_b |=>
    acc_data == ACC_RESET && simd_status_control == SCR_RESET
    && !cond_out.valid && !unavail_exc)
    else $error("state not cleared by reset");

  vec_acc_write_a: assert property (issue_s(OP_VEC_ACC_WR) |=>
    acc_data == $past(req.wdata) && st_reg.gpr[$past(req.dest)] == $past(req.wdata))
    else $error("accumulator and destination not written together");

  move_to_acc_a: assert property (issue_s(OP_MOVE_TO_ACC) |=>
    acc_data == $past(src_a_val))
    else $error("accumulator not loaded from the source register");

  sequence setcmp_s(svr_elem_type e);
    req.valid && req.op == OP_VEC_SETCMP && req.elem == e && simd_extension;
  endsequence

  // Set-compare element placement, one check per element size
  setcmp_byte_a: assert property (setcmp_s(EL_BYTE) |=>
    st_reg.gpr[$past(req.dest)][63:56] == {8{$past(req.cmp_mask[0])}}
    && st_reg.gpr[$past(req.dest)][7:0] == {8{$past(req.cmp_mask[7])}})
    else $error("set-compare byte elements misplaced");

  setcmp_half_a: assert property (setcmp_s(EL_HALF) |=>
    st_reg.gpr[$past(req.dest)][63:48] == {16{$past(req.cmp_mask[0])}}
    && st_reg.gpr[$past(req.dest)][15:0] == {16{$past(req.cmp_mask[3])}})
    else $error("set-compare halfword elements misplaced");

  setcmp_word_a: assert property (setcmp_s(EL_WORD) |=>
    st_reg.gpr[$past(req.dest)][63:32] == {32{$past(req.cmp_mask[0])}}
    && st_reg.gpr[$past(req.dest)][31:0] == {32{$past(req.cmp_mask[1])}})
    else $error("set-compare word elements misplaced");

  mac_saturate_a: assert property (mac_issue_s ##0 req.saturate ##0 mac_ovf[1] |=>
    acc_data[31:0] == SAT_POS || acc_data[31:0] == SAT_NEG)
    else $error("low accumulate lane not saturated");

  low_overflow_flag_a: assert property (mac_issue_s ##0 mac_ovf[1] |=>
    simd_status_control[SCR_OVL] && simd_status_control[SCR_SOVL])
    else $error("low overflow not flagged after accumulate");

  fp_high_flags_a: assert property (req.valid && req.flag_upd && simd_extension
    && is_vector && req.op != OP_MAC_HFRAC
    |=> simd_status_control[SCR_FPH_LSB +: FP_FLAGS] == $past(req.fp_high))
    else $error("high floating-point flags not loaded");

  fp_low_flags_a: assert property (req.valid && req.flag_upd && simd_extension
    && is_vector && req.op != OP_MAC_HFRAC
    |=> simd_status_control[SCR_FPL_LSB +: FP_FLAGS] == $past(req.fp_low))
    else $error("low floating-point flags not loaded");

  unavail_pulse_a: assert property (!blocked |=> !unavail_exc)
    else $error("unavailable raised without a refused vector op");

  brinc_allowed_a: assert property (req.valid && req.op == OP_BRINC_WR |=>
    !unavail_exc && st_reg.gpr[$past(req.dest)][31:0] == $past(req.wdata[31:0]))
    else $error("bit-reversed increment refused or lost");

endmodule // svr_regfile

// [testbench/svr_core_model.sv]
// Core pipeline model that issues requests and read addresses
`timescale 1ns/1ns
module svr_core_model
  import svr_pkg::*;
(
  input wire logic clk,
  output svr_req_type req,
  output logic simd_extension,
  output logic [4:0] rd_a_addr,
  output logic [4:0] rd_b_addr
);
  initial begin
    req = '0;
    simd_extension = 1'b1;
    rd_a_addr = 5'h00;
    rd_b_addr = 5'h00;
  end

  // -------------------------------------------------------------
  // Requests
  // -------------------------------------------------------------
  // Requests go out back to back, one a cycle; results settled on return
  task automatic issue(input svr_req_type q[$]);
    foreach (q[i]) begin
      @(posedge clk);
      req <= q[i];
    end
    @(posedge clk);
    req <= '0;
    #1;
  endtask

  // Both read ports point at one register; data lands one edge later
  task automatic addr(input logic [4:0] a);
    @(posedge clk);
    rd_a_addr <= a;
    rd_b_addr <= a;
    @(posedge clk);
    #1;
  endtask

  task automatic enable(input logic e);
    @(posedge clk);
    simd_extension <= e;
  endtask
endmodule // svr_core_model

// [testbench/tb_top.sv]
// Self-checking testbench of the vector register file
`timescale 1ns/1ns
module tb_top;
  import svr_pkg::*;
  logic clk;
  logic rst_b;
  svr_req_type req;
  logic simd_extension;
  logic [4:0] rd_a_addr;
  logic [4:0] rd_b_addr;
  logic [63:0] rd_a_data;
  logic [63:0] rd_b_data;
  logic [63:0] acc_data;
  logic [31:0] simd_status_control;
  svr_cond_type cond_out;
  logic unavail_exc;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  svr_req_type r;
  logic [1:0] m;
  logic [31:0] w;

  svr_regfile uut (.clk(clk), .rst_b(rst_b), .req(req), .simd_extension(simd_extension),
    .rd_a_addr(rd_a_addr), .rd_b_addr(rd_b_addr), .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data), .acc_data(acc_data), .simd_status_control(simd_status_control),
    .cond_out(cond_out), .unavail_exc(unavail_exc));
  svr_core_model core (.clk(clk), .req(req), .simd_extension(simd_extension),
    .rd_a_addr(rd_a_addr), .rd_b_addr(rd_b_addr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [63:0] exp, input string nm);
    core.addr(a);
    check(nm, rd_a_data, exp);
    check(nm, rd_b_data, exp);
  endtask

  function automatic svr_req_type mk(input svr_op_type op, input logic [4:0] d,
                                     input logic [4:0] a, input logic [63:0] v);
    svr_req_type q;
    q = '0;
    q.valid = 1'b1;
    q.op = op;
    q.dest = d;
    q.src_a = a;
    q.wdata = v;
    return q;
  endfunction

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      conclude();
    end
  end

  // -------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(5'h1f, GPR_RESET, "gpr_reset");
    check("acc_reset", acc_data, ACC_RESET);
    check("scr_reset", {32'h0, simd_status_control}, {32'h0, SCR_RESET});
    $display("Test reset done");
    core.issue('{mk(OP_VEC_WR, 5'h01, 5'h00, 64'h0123456789abcdef)});
    core.issue('{mk(OP_VEC_WR, 5'h1f, 5'h00, 64'hfedcba9876543210)});
    core.issue('{mk(OP_SCALAR_WR, 5'h01, 5'h00, 64'hffffffff00c0ffee)});
    rd(5'h01, 64'h0123456700c0ffee, "scalar_wr");
    rd(5'h1f, 64'hfedcba9876543210, "vector_wr");
    $display("Test register writes done");
    core.issue('{mk(OP_MOVE_TO_ACC, 5'h00, 5'h01, 64'h0)});
    check("acc_load", acc_data, 64'h0123456700c0ffee);
    core.issue('{mk(OP_MOVE_FROM_ACC, 5'h02, 5'h00, 64'h0)});
    rd(5'h02, 64'h0123456700c0ffee, "acc_copy");
    $display("Test accumulator moves done");
    core.issue('{mk(OP_VEC_WR, 5'h05, 5'h00, 64'h00007fff0000c000)});
    core.issue('{mk(OP_MOVE_TO_ACC, 5'h00, 5'h00, 64'h0)});
    r = mk(OP_MAC_HFRAC, 5'h06, 5'h05, 64'h0);
    r.bdata = 64'h00007fff00004000;
    r.saturate = 1'b1;
    core.issue('{r});
    check("mac_acc", acc_data, 64'h7ffe0002e0000000);
    check("mac_scr", {32'h0, simd_status_control}, 64'h0);
    rd(5'h06, 64'h7ffe0002e0000000, "mac_dest");
    r.dest = 5'h07;
    core.issue('{r, r});
    check("mac_sat", acc_data, 64'h7fffffffa0000000);
    check("mac_ovf", {32'h0, simd_status_control}, 64'hc0000000);
    rd(5'h07, 64'h7fffffffa0000000, "mac_b2b");
    $display("Test multiply accumulate done");
    r = mk(OP_VEC_WR, 5'h08, 5'h00, 64'h0);
    r.flag_upd = 1'b1;
    r.ovf_low = 1'b1;
    r.fp_high = 6'h3f;
    core.issue('{r});
    check("flags_set", {32'h0, simd_status_control}, 64'hbf00c000);
    r.ovf_low = 1'b0;
    r.fp_high = 6'h00;
    core.issue('{r});
    check("flags_sticky", {32'h0, simd_status_control}, 64'h80008000);
    for (int i = 0; i < 2; i++) begin
      w = (i == 0) ? 32'hffffffff : 32'h00000000;
      core.issue('{mk(OP_MOVE_TO_SCR, 5'h00, 5'h00, {32'h0, w})});
      check("scr_move", {32'h0, simd_status_control}, {32'h0, w & SCR_WRITE_MASK});
    end
    $display("Test status flags done");
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      r = mk(OP_VEC_CMP, 5'h00, 5'h00, 64'h0);
      r.crf = 3'(i + 1);
      r.cmp_mask = {6'h00, m};
      core.issue('{r});
      check("cond", {56'h0, cond_out}, {56'h0, 1'b1, r.crf, m[0], m[1], |m, &m});
    end
    core.addr(5'h00);
    check("cond_pulse", {63'h0, cond_out.valid}, 64'h0);
    $display("Test compare done");
    r = mk(OP_VEC_SETCMP, 5'h0a, 5'h00, 64'h0);
    r.elem = EL_BYTE;
    r.cmp_mask = 8'h05;
    core.issue('{r});
    rd(5'h0a, 64'hff00ff0000000000, "set_byte");
    r.elem = EL_HALF;
    r.cmp_mask = 8'h09;
    core.issue('{r});
    rd(5'h0a, 64'hffff00000000ffff, "set_half");
    r.elem = EL_WORD;
    r.cmp_mask = 8'h02;
    core.issue('{r});
    rd(5'h0a, 64'h00000000ffffffff, "set_word");
    $display("Test set compare done");
    core.issue('{mk(OP_VEC_ACC_WR, 5'h0b, 5'h00, 64'h8000000080000000)});
    check("acc_wr", acc_data, 64'h8000000080000000);
    rd(5'h0b, 64'h8000000080000000, "acc_wr_dest");
    r = mk(OP_MAC_HFRAC, 5'h0c, 5'h05, 64'h0);
    r.bdata = 64'h0000400000004000;
    r.saturate = 1'b1;
    core.issue('{r});
    check("mac_neg_sat", acc_data, 64'hbfff800080000000);
    check("mac_low_ovf", {32'h0, simd_status_control}, 64'h0000c000);
    rd(5'h0c, 64'hbfff800080000000, "mac_neg_dest");
    $display("Test accumulate write done");
    core.enable(1'b0);
    core.issue('{mk(OP_VEC_WR, 5'h01, 5'h00, 64'h0)});
    check("unavail", {63'h0, unavail_exc}, 64'h1);
    core.issue('{mk(OP_BRINC_WR, 5'h09, 5'h00, 64'h0)});
    check("brinc_ok", {63'h0, unavail_exc}, 64'h0);
    rd(5'h01, 64'h0123456700c0ffee, "refused_kept");
    core.enable(1'b1);
    $display("Test unavailable done");
    conclude();
  end
endmodule // tb_top
